// ### design/oct_trip.sv
// over-current tier qualification, trip flags and notification
// Behaviour
// - tier-one code 00 off, else 10/15/20
// - trip sets byte, word, iout fault flags
// - trip drops power good, raises alert unless alert_mask is set
// - each tier has own detect-to-shutdown delay
// - delay codes 0.25/1/10/50 ms, tier three 01
// - tier-two delay bits 5:4, reset 00
// - tier-one delay bits 3:2, reset 00
// - tier-three thresholds 50/60/70/80, reset 80
// - tier-two 00 off, reset off, else 25/35/45
// - status byte bit four shows over-current
`timescale 1ns/1ps
module oct_trip
  import oct_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire oct_reg_req_s       reg_req,
  input  wire logic               flags_clear,
  input  wire logic               alert_mask,
  input  wire logic [CUR_W-1:0]   iout_level,
  output logic [15:0]             protection_setup,
  output oct_flags_s              overcurrent_fault_flag,
  output logic [7:0]              status_byte,
  output logic                    power_good_output,
  output logic                    alert_n,
  output logic                    path_off
);

  // threshold of a tier for its level code; an off code is gated by tier_on
  function automatic logic [CUR_W-1:0] tier_thr(input int t, input logic [1:0] c);
    logic [CUR_W-1:0] r;
    r = '0;
    unique case (t)
      0: begin
        unique case (c)
          2'b00: r = '0;
          2'b01: r = THR_T1_01;
          2'b10: r = THR_T1_10;
          2'b11: r = THR_T1_11;
        endcase
      end
      1: begin
        unique case (c)
          2'b00: r = '0;
          2'b01: r = THR_T2_01;
          2'b10: r = THR_T2_10;
          2'b11: r = THR_T2_11;
        endcase
      end
      default: begin
        unique case (c)
          2'b00: r = THR_T3_00;
          2'b01: r = THR_T3_01;
          2'b10: r = THR_T3_10;
          2'b11: r = THR_T3_11;
        endcase
      end
    endcase
    return r;
  endfunction : tier_thr

  // tier three has no off code
  function automatic logic tier_on(input int t, input logic [1:0] c);
    return (t == NUM_TIERS - 1) || (c != 2'b00);
  endfunction : tier_on

  // level code of a tier in the setup word
  function automatic logic [1:0] lvl_code(input int t, input logic [15:0] w);
    logic [1:0] c;
    c = '0;
    unique case (t)
      0:       c = w[T1_LVL_HI:T1_LVL_LO];
      1:       c = w[T2_LVL_HI:T2_LVL_LO];
      default: c = w[T3_LVL_HI:T3_LVL_LO];
    endcase
    return c;
  endfunction : lvl_code

  // delay code of a tier in the setup word
  function automatic logic [1:0] dly_code(input int t, input logic [15:0] w);
    logic [1:0] c;
    c = '0;
    unique case (t)
      0:       c = w[T1_DLY_HI:T1_DLY_LO];
      1:       c = w[T2_DLY_HI:T2_DLY_LO];
      default: c = w[T3_DLY_HI:T3_DLY_LO];
    endcase
    return c;
  endfunction : dly_code

  function automatic logic [CNT_W-1:0] tier_dly(input logic [1:0] c);
    logic [CNT_W-1:0] r;
    r = DLY0_CYC;
    unique case (c)
      2'b00: r = DLY0_CYC;
      2'b01: r = DLY1_CYC;
      2'b10: r = DLY2_CYC;
      2'b11: r = DLY3_CYC;
    endcase
    return r;
  endfunction : tier_dly

  logic setup_we;
  assign setup_we = reg_req.wr && (reg_req.addr == SETUP_ADDR);

  // configuration register; bits 15:14 read as zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      protection_setup <= SETUP_RESET;
    end else if (setup_we) begin
      protection_setup <= reg_req.wdata & SETUP_WR_MASK;
    end
  end

  logic [1:0] lvl [NUM_TIERS];
  logic [1:0] dly [NUM_TIERS];

  logic [NUM_TIERS-1:0] expired;

  // one detector and qualification timer per tier
  genvar g;
  generate
    for (g = 0; g < NUM_TIERS; g++) begin : g_tier
      logic             over;
      logic [CNT_W-1:0] limit;
      logic [CNT_W-1:0] cnt;
      assign lvl[g] = lvl_code(g, protection_setup);
      assign dly[g] = dly_code(g, protection_setup);
      assign over  = tier_on(g, lvl[g]) && (iout_level > tier_thr(g, lvl[g]));
      assign limit = tier_dly(dly[g]);
      // counter stops at the limit, so a long over-current cannot wrap it
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          cnt <= '0;
        end else if (!over) begin
          cnt <= '0;
        end else if (cnt < limit) begin
          cnt <= cnt + CNT_W'(1);
        end
      end
      assign expired[g] = over && (cnt >= limit);
    end
  endgenerate

  logic trip;
  assign trip = |expired;

  // sticky flags; a trip in the clear cycle wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overcurrent_fault_flag <= '0;
    end else if (trip) begin
      overcurrent_fault_flag <= '1;
    end else if (flags_clear) begin
      overcurrent_fault_flag <= '0;
    end
  end

  // only the over-current bit of the status byte is kept here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= '0;
    end else if (trip) begin
      status_byte[STATUS_OC_BIT] <= 1'b1;
    end else if (flags_clear) begin
      status_byte[STATUS_OC_BIT] <= 1'b0;
    end
  end

  typedef enum logic {
    OCT_PATH_ON,
    OCT_PATH_SHUT
  } oct_path_e;

  oct_path_e path_state;
  oct_path_e next_path_state;

  // the path stays shut while any tier is still expired
  always_comb begin
    next_path_state = path_state;
    unique case (path_state)
      OCT_PATH_ON: begin
        if (trip) begin
          next_path_state = OCT_PATH_SHUT;
        end
      end
      OCT_PATH_SHUT: begin
        if (!trip && flags_clear) begin
          next_path_state = OCT_PATH_ON;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      path_state <= OCT_PATH_ON;
    end else begin
      path_state <= next_path_state;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      path_off <= 1'b0;
    end else begin
      path_off <= (next_path_state == OCT_PATH_SHUT);
    end
  end

  // power good is low for as long as the path is shut
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      power_good_output <= 1'b1;
    end else begin
      power_good_output <= (next_path_state == OCT_PATH_ON);
    end
  end

  // a masked alert stays high; the mask is taken on every trip cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alert_n <= 1'b1;
    end else if (trip) begin
      alert_n <= alert_mask;
    end else if (flags_clear) begin
      alert_n <= 1'b1;
    end
  end

endmodule : oct_trip

// ### shared/oct_pkg.sv
// package for the over-current trip timing block
package oct_pkg;
  localparam logic [7:0]  SETUP_ADDR      = 8'hc9;
  localparam logic [15:0] SETUP_RESET     = 16'h3041;
  localparam logic [15:0] SETUP_WR_MASK   = 16'h3fff;
  localparam int          T3_LVL_HI       = 13;
  localparam int          T3_LVL_LO       = 12;
  localparam int          T2_LVL_HI       = 11;
  localparam int          T2_LVL_LO       = 10;
  localparam int          T1_LVL_HI       = 9;
  localparam int          T1_LVL_LO       = 8;
  localparam int          T3_DLY_HI       = 7;
  localparam int          T3_DLY_LO       = 6;
  localparam int          T2_DLY_HI       = 5;
  localparam int          T2_DLY_LO       = 4;
  localparam int          T1_DLY_HI       = 3;
  localparam int          T1_DLY_LO       = 2;
  localparam int          NUM_TIERS       = 3;
  localparam int          CUR_W           = 8;
  localparam int          STATUS_OC_BIT   = 4;
  // trip thresholds in output-current units
  localparam logic [7:0]  THR_T1_01 = 8'h0a;
  localparam logic [7:0]  THR_T1_10 = 8'h0f;
  localparam logic [7:0]  THR_T1_11 = 8'h14;
  localparam logic [7:0]  THR_T2_01 = 8'h19;
  localparam logic [7:0]  THR_T2_10 = 8'h23;
  localparam logic [7:0]  THR_T2_11 = 8'h2d;
  localparam logic [7:0]  THR_T3_00 = 8'h32;
  localparam logic [7:0]  THR_T3_01 = 8'h3c;
  localparam logic [7:0]  THR_T3_10 = 8'h46;
  localparam logic [7:0]  THR_T3_11 = 8'h50;
  // qualification delays in microseconds and cycles at 200 MHz
  localparam int          CLK_MHZ   = 200;
  localparam int          DLY0_US   = 250;
  localparam int          DLY1_US   = 1000;
  localparam int          DLY2_US   = 10000;
  localparam int          DLY3_US   = 50000;
  localparam int          CNT_W     = 24;
  localparam logic [CNT_W-1:0] DLY0_CYC = CNT_W'(DLY0_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY1_CYC = CNT_W'(DLY1_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY2_CYC = CNT_W'(DLY2_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY3_CYC = CNT_W'(DLY3_US * CLK_MHZ);

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } oct_reg_req_s;

  typedef struct packed {
    logic       status_byte_oc;
    logic       status_word_iout;
    logic       status_iout_oc;
  } oct_flags_s;
endpackage : oct_pkg

// ### testbench/oct_host.sv
// host model that writes the setup register
`timescale 1ns/1ps
module oct_host
  import oct_pkg::*;
(
  input  logic         clk_sys,
  output oct_reg_req_s reg_req
);
  initial reg_req = '0;
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys) reg_req = '{1'b1, a, d};
    @(negedge clk_sys) reg_req.wr = 1'b0;
  endtask : wr
endmodule : oct_host

// ### testbench/oct_trip_props.sv
// assertions on the over-current trip block ports
`timescale 1ns/1ps
module oct_trip_props
  import oct_pkg::*;
(
  input logic         clk_sys,
  input logic         arst_n,
  input oct_reg_req_s reg_req,
  input logic         alert_mask,
  input logic [7:0]   iout_level,
  input logic [15:0]  protection_setup,
  input oct_flags_s   overcurrent_fault_flag,
  input logic [7:0]   status_byte,
  input logic         power_good_output,
  input logic         alert_n,
  input logic         path_off
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire take = reg_req.wr && reg_req.addr == SETUP_ADDR;
  chk_write_take: assert property (take |=>
    protection_setup == ($past(reg_req.wdata) & SETUP_WR_MASK)) else $error("setup write lost");
  chk_other_addr: assert property (!take |=> $stable(protection_setup))
    else $error("setup changed without write");
  chk_trip_flags: assert property ($rose(path_off) |-> overcurrent_fault_flag == 3'b111)
    else $error("fault flags not set on trip");
  chk_status_bit: assert property ($rose(path_off) |-> status_byte == 8'h10)
    else $error("status byte wrong on trip");
  chk_alert_mask: assert property ($rose(path_off) |-> alert_n == $past(alert_mask))
    else $error("alert wrong on trip");
  chk_good_pair: assert property (power_good_output == !path_off)
    else $error("power good disagrees with path");
  chk_trip_cause: assert property ($rose(path_off) |-> $past(iout_level, 2) > THR_T1_01)
    else $error("trip without over-current");
  chk_unused_bits: assert property (protection_setup[15:14] == 2'b00 &&
    status_byte[3:0] == 4'h0) else $error("unused bits set");
endmodule : oct_trip_props

// ### testbench/overcurrent_trip_timing_bench.sv
// self-checking bench for the over-current trip block
`timescale 1ns/1ps
module overcurrent_trip_timing_bench;
  import oct_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} oct_row_s;
  logic clk_sys, arst_n, flags_clear, alert_mask, power_good_output, alert_n, path_off;
  logic [7:0] iout_level, status_byte;
  logic [15:0] protection_setup;
  oct_reg_req_s reg_req;
  oct_flags_s flg;
  int n_fail, cmp_count;
  oct_row_s rows [3] = '{'{8'hc9, 16'hffff, 16'h3fff}, '{8'h12, 16'h0000, 16'h3fff},
                         '{8'hc9, 16'h0100, 16'h0100}};
  oct_host HOST (.clk_sys(clk_sys), .reg_req(reg_req));
  oct_trip DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req), .flags_clear(flags_clear),
    .alert_mask(alert_mask), .iout_level(iout_level), .protection_setup(protection_setup),
    .overcurrent_fault_flag(flg), .status_byte(status_byte),
    .power_good_output(power_good_output), .alert_n(alert_n), .path_off(path_off));
  logic [15:0] obs;
  assign obs = {2'b00, power_good_output, alert_n, path_off, flg, status_byte};
  task cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task complete_run;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #450us;
    n_fail++;
    complete_run;
  end
  initial begin
    arst_n = 0; flags_clear = 0; alert_mask = 0; iout_level = 8'h00;
    repeat (16) @(negedge clk_sys);
    arst_n = 1;
    cmp(protection_setup, SETUP_RESET);
    cmp(obs, {5'b00110, 3'b000, 8'h00});
    for (int i = 0; i < 3; i++) begin
      HOST.wr(rows[i].a, rows[i].d);
      cmp(protection_setup, rows[i].e);
    end
    iout_level = 8'h0b;
    repeat (30000) @(negedge clk_sys);
    iout_level = 8'h00;
    @(negedge clk_sys) iout_level = 8'h0b;
    repeat (49990) @(negedge clk_sys);
    cmp(path_off, 1'b0);
    repeat (20) @(negedge clk_sys);
    cmp(obs, {5'b00001, 3'b111, 8'h10});
    alert_mask = 1;
    flags_clear = 1;
    @(negedge clk_sys) flags_clear = 0;
    cmp(obs, {5'b00011, 3'b111, 8'h10});
    iout_level = 8'h00;
    repeat (2) @(negedge clk_sys);
    flags_clear = 1;
    @(negedge clk_sys) flags_clear = 0;
    cmp(obs, {5'b00110, 3'b000, 8'h00});
    complete_run;
  end
endmodule : overcurrent_trip_timing_bench
bind oct_trip oct_trip_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req),
  .alert_mask(alert_mask), .iout_level(iout_level), .protection_setup(protection_setup),
  .overcurrent_fault_flag(overcurrent_fault_flag), .status_byte(status_byte),
  .power_good_output(power_good_output), .alert_n(alert_n), .path_off(path_off));
